// ---- eps_defs.svh ----
/*
 * Constants of the excitation protection supervisor: time figures,
 * thresholds, setting limits and reset values of the settings.
 * Assumes measured quantities arrive already scaled as listed here.
 */
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH

// Clock rate and the protection time base
`define EPS_CLK_HZ        10000000
`define EPS_TICK_S        1
`define EPS_TICK_CYCLES   (`EPS_CLK_HZ * `EPS_TICK_S)

// Timer channel indices
`define EPS_CH_SENSE      0
`define EPS_CH_FOV        1
`define EPS_CH_LIM        2
`define EPS_CH_UEL        3
`define EPS_CH_BOOT       4
`define EPS_CH_SOFT       5
`define EPS_NCH           6

// Fixed times, seconds
`define EPS_FOV_DELAY_S   13'h000A
`define EPS_BOOT_SHOW_S   13'h0005

// Thresholds: voltages in percent, frequency in 0.1 Hz, current in 0.1 pu
`define EPS_SENSE_LOW_PCT 8'h32
`define EPS_SENSE_DEV_PCT 8'h14
`define EPS_MIN_FREQ_DHZ  10'h078
`define EPS_SHORT_IB_DPU  8'h1E

// Setting limits
`define EPS_FOV_SP_MAX    8'hFA
`define EPS_LIM_SP_MAX    8'h96
`define EPS_UEL_SP_MAX    8'h64
`define EPS_SL_DLY_MAX    5'h19
`define EPS_LIM_DLY_MAX   4'hA
`define EPS_SS_MIN        13'h0001
`define EPS_SS_MAX        13'h1C20

// Reset values of the settings
`define EPS_SL_DLY_RST    5'h0A
`define EPS_FOV_SP_RST    8'hFA
`define EPS_OEL_SP_RST    8'h96
`define EPS_EL_SP_RST     8'h96
`define EPS_UEL_SP_RST    8'h64
`define EPS_LIM_DLY_RST   4'hA
`define EPS_UEL_DLY_RST   4'hA
`define EPS_SS_RST        13'h000A

`endif

// ---- eps_pkg.sv ----
/*
 * Types of the excitation protection supervisor.
 * Assumes eps_defs.svh is available on the include path.
 */
package eps_pkg;

	// Cause kept in non-volatile storage across power removal
	typedef enum logic [2:0] {
		EPS_ALM_NONE  = 3'h0,
		EPS_ALM_SENSE = 3'h1,
		EPS_ALM_FOV   = 3'h2,
		EPS_ALM_OEL   = 3'h3,
		EPS_ALM_UEL   = 3'h4
	} eps_alarm_e;

	typedef logic [12:0] eps_sec_t;

	typedef struct packed {
		eps_sec_t count;
	} eps_delay_s;

endpackage

// ---- eps_delay.sv ----
/*
 * One protection delay: counts whole seconds while its condition holds,
 * clears at once when the condition drops.
 * Assumes a one-cycle seconds tick from the caller.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_defs.svh"

module eps_delay
	import eps_pkg::*;
(
	input  wire logic     CORE_CLK,
	input  wire logic     RST,
	input  wire logic     TICK,
	input  wire logic     COND,
	input  wire eps_sec_t LIMIT,
	output logic          EXPIRED
);

	eps_delay_s st_reg;
	eps_delay_s st_next;

	always_comb begin
		st_next = st_reg;
		if (!COND) begin
			st_next.count = '0;
		end else if (TICK && st_reg.count != '1) begin
			st_next.count = st_reg.count + 13'h0001;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// A zero limit acts as soon as the condition is seen
	assign EXPIRED = COND && (st_reg.count >= LIMIT);

endmodule

`default_nettype wire

// ---- eps_top.sv ----
/*
 * Excitation protection supervisor: sensing loss, field overvoltage,
 * field current limiters, underexcitation limiter, soft start timing
 * and voltage-matching mode, with alarm relay and indicators.
 * Assumes threshold inputs are synchronous, scaled as in eps_defs.svh,
 * and that NV_LAST_ALARM holds the code last saved from LAST_ALARM.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_defs.svh"

module eps_top
	import eps_pkg::*;
#(
	parameter int TICK_CYCLES = `EPS_TICK_CYCLES
)(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  GEN_V_PCT,
	input  wire logic [2:0]  PHASE_LOST,
	input  wire logic [7:0]  PHASE_DEV_A_PCT,
	input  wire logic [7:0]  PHASE_DEV_B_PCT,
	input  wire logic [7:0]  PHASE_DEV_C_PCT,
	input  wire logic [9:0]  FREQ_DHZ,
	input  wire logic [7:0]  IB_DPU,
	input  wire logic [7:0]  FIELD_V,
	input  wire logic [7:0]  FIELD_I_DA,
	input  wire logic [7:0]  LEAD_VAR_PCT,
	input  wire logic        TIE_BRK_CLOSED,
	input  wire logic        GEN_BRK_CLOSED,
	input  wire logic        UF_ACTIVE,
	input  wire logic        VM_MATCHED,
	input  wire logic [2:0]  NV_LAST_ALARM,
	input  wire logic        SENSE_3PH,
	input  wire logic        SL_ACTION_XFER,
	input  wire logic        FOV_ACT_RELAY,
	input  wire logic        FOV_ACT_SHUTDOWN,
	input  wire logic        LIM_TAKEOVER,
	input  wire logic        LIM_HW_SHUTDOWN,
	input  wire logic        SECOND_LIM_EN,
	input  wire logic        UEL_HW_SHUTDOWN,
	input  wire logic        VM_MAINTAIN,
	input  wire logic        RETURN_AUTO,
	input  wire logic        CFG_LOAD,
	input  wire logic [4:0]  CFG_SL_DELAY,
	input  wire logic [7:0]  CFG_FOV_SP,
	input  wire logic [7:0]  CFG_OEL_SP,
	input  wire logic [7:0]  CFG_EL_SP,
	input  wire logic [3:0]  CFG_LIM_DELAY,
	input  wire logic [7:0]  CFG_UEL_SP,
	input  wire logic [3:0]  CFG_UEL_DELAY,
	input  wire logic [12:0] CFG_SS_TIME,
	output logic             CFG_REJECT,
	output logic             ALARM_RELAY_CLOSED,
	output logic             IND_SENSE_LOSS,
	output logic             IND_FOV_SHUTDOWN,
	output logic             IND_OEL_LIMITING,
	output logic             IND_UEL_LIMITING,
	output logic             DISABLE,
	output logic             FIELD_CURRENT_MODE,
	output logic             TAKEOVER_FORCE,
	output logic             SOFT_START_ACTIVE,
	output logic [12:0]      SS_ELAPSED,
	output logic             UF_PRIORITY,
	output logic             VM_HOLD_BUS,
	output logic [2:0]       LAST_ALARM
);

	typedef struct packed {
		logic [23:0] tick_cnt;
		logic        tick;
		logic        boot_done;
		eps_alarm_e  boot_code;
		eps_alarm_e  last_alarm;
		logic        shutdown;
		logic        field_current_mode;
		logic        sense_latch;
		logic [4:0]  sl_dly;
		logic [7:0]  fov_sp;
		logic [7:0]  oel_sp;
		logic [7:0]  el_sp;
		logic [3:0]  lim_dly;
		logic [7:0]  uel_sp;
		logic [3:0]  uel_dly;
		eps_sec_t    ss_time;
		eps_sec_t    ss_elapsed;
		logic        cfg_reject;
		logic        relay;
		logic        ind_sense;
		logic        ind_fov;
		logic        ind_oel;
		logic        ind_uel;
		logic        takeover;
		logic        uf_prio;
		logic        vm_hold;
	} eps_state_s;

	eps_state_s st_reg;
	eps_state_s st_next;

	logic [`EPS_NCH-1:0] ch_cond;
	logic [`EPS_NCH-1:0] ch_exp;
	eps_sec_t            ch_limit [`EPS_NCH];

	logic [7:0] dev_pct [3];
	logic [2:0] dev_over;
	logic       sense_raw;
	logic       sense_inhibit;
	logic       sense_cond;
	logic       soft_active;
	logic       boot_show;
	logic       fov_over;
	logic       lim_over;
	logic       uel_enable;
	logic       uel_over;
	logic       cfg_ok;

	assign dev_pct[0] = PHASE_DEV_A_PCT;
	assign dev_pct[1] = PHASE_DEV_B_PCT;
	assign dev_pct[2] = PHASE_DEV_C_PCT;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_dev
			assign dev_over[gi] = dev_pct[gi] > `EPS_SENSE_DEV_PCT;
		end
		for (gi = 0; gi < `EPS_NCH; gi++) begin : g_tmr
			eps_delay u_dly (
				.CORE_CLK (CORE_CLK),
				.RST      (RST),
				.TICK     (st_reg.tick),
				.COND     (ch_cond[gi]),
				.LIMIT    (ch_limit[gi]),
				.EXPIRED  (ch_exp[gi])
			);
		end
	endgenerate

	// Boot and soft-start timers run from the first cycle after reset
	assign ch_cond[`EPS_CH_BOOT] = 1'b1;
	assign ch_cond[`EPS_CH_SOFT] = 1'b1;
	assign ch_limit[`EPS_CH_BOOT] = `EPS_BOOT_SHOW_S;
	assign ch_limit[`EPS_CH_SOFT] = st_reg.ss_time;
	assign soft_active = !ch_exp[`EPS_CH_SOFT];
	assign boot_show   = st_reg.boot_done && !ch_exp[`EPS_CH_BOOT];

	always_comb begin
		sense_raw = GEN_V_PCT < `EPS_SENSE_LOW_PCT;
		if (SENSE_3PH) begin
			sense_raw = sense_raw || (|PHASE_LOST)
				|| (|dev_over);
		end
	end

	assign sense_inhibit = (FREQ_DHZ < `EPS_MIN_FREQ_DHZ)
		|| (IB_DPU > `EPS_SHORT_IB_DPU) || soft_active;
	assign sense_cond = sense_raw && !sense_inhibit;
	assign ch_cond[`EPS_CH_SENSE]  = sense_cond;
	assign ch_limit[`EPS_CH_SENSE] = {8'h00, st_reg.sl_dly};

	assign fov_over = FIELD_V > st_reg.fov_sp;
	assign ch_cond[`EPS_CH_FOV]  = fov_over;
	assign ch_limit[`EPS_CH_FOV] = `EPS_FOV_DELAY_S;

	// Second limiter never sits above the first, so it is the tighter one
	assign lim_over = SECOND_LIM_EN ? (FIELD_I_DA > st_reg.el_sp)
		: (FIELD_I_DA > st_reg.oel_sp);
	assign ch_cond[`EPS_CH_LIM]  = lim_over;
	assign ch_limit[`EPS_CH_LIM] = {9'h000, st_reg.lim_dly};

	assign uel_enable = !TIE_BRK_CLOSED || !GEN_BRK_CLOSED;
	assign uel_over   = uel_enable && (LEAD_VAR_PCT > st_reg.uel_sp);
	assign ch_cond[`EPS_CH_UEL]  = uel_over;
	assign ch_limit[`EPS_CH_UEL] = {9'h000, st_reg.uel_dly};

	assign cfg_ok = (CFG_SL_DELAY <= `EPS_SL_DLY_MAX)
		&& (CFG_FOV_SP <= `EPS_FOV_SP_MAX)
		&& (CFG_OEL_SP <= `EPS_LIM_SP_MAX)
		&& (CFG_EL_SP <= CFG_OEL_SP)
		&& (CFG_LIM_DELAY <= `EPS_LIM_DLY_MAX)
		&& (CFG_UEL_SP <= `EPS_UEL_SP_MAX)
		&& (CFG_UEL_DELAY <= `EPS_LIM_DLY_MAX)
		&& (CFG_SS_TIME >= `EPS_SS_MIN)
		&& (CFG_SS_TIME <= `EPS_SS_MAX);

	always_comb begin
		st_next = st_reg;

		// Seconds tick from the system clock
		st_next.tick = 1'b0;
		if (st_reg.tick_cnt == 24'(TICK_CYCLES - 1)) begin
			st_next.tick_cnt = '0;
			st_next.tick     = 1'b1;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 24'h00_0001;
		end

		// Stored cause is sampled once, the cycle after reset release
		if (!st_reg.boot_done) begin
			st_next.boot_done = 1'b1;
			st_next.boot_code = eps_alarm_e'(NV_LAST_ALARM);
		end

		// Whole setting set is taken or refused together
		st_next.cfg_reject = CFG_LOAD && !cfg_ok;
		if (CFG_LOAD && cfg_ok) begin
			st_next.sl_dly  = CFG_SL_DELAY;
			st_next.fov_sp  = CFG_FOV_SP;
			st_next.oel_sp  = CFG_OEL_SP;
			st_next.el_sp   = CFG_EL_SP;
			st_next.lim_dly = CFG_LIM_DELAY;
			st_next.uel_sp  = CFG_UEL_SP;
			st_next.uel_dly = CFG_UEL_DELAY;
			st_next.ss_time = CFG_SS_TIME;
		end

		// Sensing loss
		if (sense_cond && SL_ACTION_XFER) begin
			st_next.sense_latch = 1'b1;
		end else if (!sense_raw) begin
			st_next.sense_latch = 1'b0;
		end
		if (ch_exp[`EPS_CH_SENSE]) begin
			if (SL_ACTION_XFER) begin
				st_next.field_current_mode = 1'b1;
			end else begin
				st_next.shutdown = 1'b1;
			end
		end
		// Return to automatic is ignored while a transfer is being made
		if (RETURN_AUTO && !ch_exp[`EPS_CH_SENSE]) begin
			st_next.field_current_mode = 1'b0;
		end

		// Field overvoltage
		if (ch_exp[`EPS_CH_FOV] && FOV_ACT_SHUTDOWN) begin
			st_next.shutdown = 1'b1;
		end
		// Limiters with optional hardware shutdown
		if (ch_exp[`EPS_CH_LIM] && LIM_HW_SHUTDOWN) begin
			st_next.shutdown = 1'b1;
		end
		if (ch_exp[`EPS_CH_UEL] && UEL_HW_SHUTDOWN) begin
			st_next.shutdown = 1'b1;
		end

		// Cause to be saved in non-volatile storage
		if (sense_cond) begin
			st_next.last_alarm = EPS_ALM_SENSE;
		end else if (ch_exp[`EPS_CH_FOV] && FOV_ACT_SHUTDOWN) begin
			st_next.last_alarm = EPS_ALM_FOV;
		end else if (ch_exp[`EPS_CH_LIM] && LIM_HW_SHUTDOWN) begin
			st_next.last_alarm = EPS_ALM_OEL;
		end else if (ch_exp[`EPS_CH_UEL] && UEL_HW_SHUTDOWN) begin
			st_next.last_alarm = EPS_ALM_UEL;
		end

		// Relay is closed when healthy; it latches open only through a latched shutdown
		st_next.relay = !(sense_cond
			|| (ch_exp[`EPS_CH_FOV] && FOV_ACT_RELAY)
			|| ch_exp[`EPS_CH_LIM]
			|| ch_exp[`EPS_CH_UEL]
			|| st_reg.shutdown);

		st_next.ind_sense = sense_cond || st_reg.sense_latch
			|| (boot_show && st_reg.boot_code == EPS_ALM_SENSE);
		st_next.ind_fov = (ch_exp[`EPS_CH_FOV] && FOV_ACT_RELAY)
			|| (boot_show && st_reg.boot_code == EPS_ALM_FOV);
		st_next.ind_oel = lim_over
			|| (boot_show && st_reg.boot_code == EPS_ALM_OEL);
		st_next.ind_uel = uel_over
			|| (boot_show && st_reg.boot_code == EPS_ALM_UEL);
		// Inverse-time curve itself is shaped by the current regulator
		st_next.takeover = LIM_TAKEOVER && lim_over;

		// Soft start ramp progress
		if (soft_active && st_reg.tick) begin
			st_next.ss_elapsed = st_reg.ss_elapsed + 13'h0001;
		end
		st_next.uf_prio = soft_active && UF_ACTIVE;

		// Revert drops the bus level as soon as either breaker opens
		st_next.vm_hold = VM_MATCHED && (VM_MAINTAIN
			|| (TIE_BRK_CLOSED && GEN_BRK_CLOSED));
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_reg            <= '0;
			st_reg.boot_code  <= EPS_ALM_NONE;
			st_reg.last_alarm <= EPS_ALM_NONE;
			st_reg.sl_dly     <= `EPS_SL_DLY_RST;
			st_reg.fov_sp     <= `EPS_FOV_SP_RST;
			st_reg.oel_sp     <= `EPS_OEL_SP_RST;
			st_reg.el_sp      <= `EPS_EL_SP_RST;
			st_reg.lim_dly    <= `EPS_LIM_DLY_RST;
			st_reg.uel_sp     <= `EPS_UEL_SP_RST;
			st_reg.uel_dly    <= `EPS_UEL_DLY_RST;
			st_reg.ss_time    <= `EPS_SS_RST;
			st_reg.relay      <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign CFG_REJECT         = st_reg.cfg_reject;
	assign ALARM_RELAY_CLOSED = st_reg.relay;
	assign IND_SENSE_LOSS     = st_reg.ind_sense;
	assign IND_FOV_SHUTDOWN   = st_reg.ind_fov;
	assign IND_OEL_LIMITING   = st_reg.ind_oel;
	assign IND_UEL_LIMITING   = st_reg.ind_uel;
	assign DISABLE            = st_reg.shutdown;
	assign FIELD_CURRENT_MODE = st_reg.field_current_mode;
	assign TAKEOVER_FORCE     = st_reg.takeover;
	assign SOFT_START_ACTIVE  = soft_active;
	assign SS_ELAPSED         = st_reg.ss_elapsed;
	assign UF_PRIORITY        = st_reg.uf_prio;
	assign VM_HOLD_BUS        = st_reg.vm_hold;
	assign LAST_ALARM         = st_reg.last_alarm;

endmodule

`default_nettype wire

// ---- eps_asserts.sv ----
/*
 * Checker of eps_top: settings refusal, latched actions, breaker gating.
 * Assumes it is bound to eps_top and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_defs.svh"

module eps_asserts
	import eps_pkg::*;
(
	input wire logic	CORE_CLK,
	input wire logic	RST,
	input wire logic	CFG_LOAD,
	input wire logic [7:0]	CFG_FOV_SP,
	input wire logic [7:0]	CFG_OEL_SP,
	input wire logic [7:0]	CFG_EL_SP,
	input wire logic	CFG_REJECT,
	input wire logic	TIE_BRK_CLOSED,
	input wire logic	GEN_BRK_CLOSED,
	input wire logic [2:0]	NV_LAST_ALARM,
	input wire logic	RETURN_AUTO,
	input wire logic	VM_MAINTAIN,
	input wire logic	ALARM_RELAY_CLOSED,
	input wire logic	IND_UEL_LIMITING,
	input wire logic	DISABLE,
	input wire logic	FIELD_CURRENT_MODE,
	input wire logic	SOFT_START_ACTIVE,
	input wire logic	VM_HOLD_BUS
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_bad_fov; CFG_LOAD && CFG_FOV_SP > `EPS_FOV_SP_MAX; endsequence
	sequence s_bad_el; CFG_LOAD && CFG_EL_SP > CFG_OEL_SP; endsequence
	// Boot display of a stored underexcitation cause may light it legally
	sequence s_paralleled;
		TIE_BRK_CLOSED && GEN_BRK_CLOSED
			&& NV_LAST_ALARM != EPS_ALM_UEL;
	endsequence

	property p_fov_ref; s_bad_fov |=> CFG_REJECT; endproperty
	a_fov_ref: assert property (p_fov_ref)
		else $error("fov setpoint over range accepted");
	property p_el_ref; s_bad_el |=> CFG_REJECT; endproperty
	a_el_ref: assert property (p_el_ref)
		else $error("second limiter above first accepted");
	property p_dis_hold; DISABLE |=> DISABLE; endproperty
	a_dis_hold: assert property (p_dis_hold)
		else $error("shutdown released without reset");
	property p_dis_relay; DISABLE |-> ##[0:1] !ALARM_RELAY_CLOSED; endproperty
	a_dis_relay: assert property (p_dis_relay)
		else $error("relay closed while shut down");
	property p_fcm_hold;
		FIELD_CURRENT_MODE && !RETURN_AUTO |=> FIELD_CURRENT_MODE;
	endproperty
	a_fcm_hold: assert property (p_fcm_hold)
		else $error("field current mode left on its own");
	property p_fcm_ss;
		$rose(FIELD_CURRENT_MODE) |-> !$past(SOFT_START_ACTIVE);
	endproperty
	a_fcm_ss: assert property (p_fcm_ss)
		else $error("transfer during soft start");
	property p_uel_par; s_paralleled |=> !IND_UEL_LIMITING; endproperty
	a_uel_par: assert property (p_uel_par)
		else $error("underexcitation active with both breakers closed");
	property p_revert;
		!VM_MAINTAIN && !(TIE_BRK_CLOSED && GEN_BRK_CLOSED)
			|-> ##[1:2] !VM_HOLD_BUS;
	endproperty
	a_revert: assert property (p_revert)
		else $error("bus level held after breaker opened");
endmodule

bind eps_top eps_asserts u_eps_asserts (.CORE_CLK, .RST, .CFG_LOAD,
	.CFG_FOV_SP, .CFG_OEL_SP, .CFG_EL_SP, .CFG_REJECT, .TIE_BRK_CLOSED,
	.GEN_BRK_CLOSED, .NV_LAST_ALARM, .RETURN_AUTO, .VM_MAINTAIN,
	.ALARM_RELAY_CLOSED, .IND_UEL_LIMITING, .DISABLE, .FIELD_CURRENT_MODE,
	.SOFT_START_ACTIVE, .VM_HOLD_BUS);
`default_nettype wire

// ---- eps_partner.sv ----
/*
 * Far side model: generator sensing quantities seen by eps_top.
 * Assumes FAULT is driven just after a clock edge by the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module eps_partner (
	input wire logic	CORE_CLK,
	input wire logic [2:0]	FAULT,
	output logic [7:0]	GEN_V_PCT,
	output logic [2:0]	PHASE_LOST,
	output logic [7:0]	PHASE_DEV_A_PCT,
	output logic [7:0]	PHASE_DEV_B_PCT,
	output logic [7:0]	PHASE_DEV_C_PCT,
	output logic [9:0]	FREQ_DHZ,
	output logic [7:0]	IB_DPU
);
	// Healthy voltage and phase A and B deviation readings wander every cycle so a stale value never passes
	logic [3:0]	jit = 4'h0;

	always @(posedge CORE_CLK) begin
		jit <= jit + 4'h1;
	end
	assign GEN_V_PCT = (FAULT == 3'h1 || FAULT > 3'h3) ?
		8'h28 : 8'h64 - {4'h0, jit};
	assign PHASE_LOST = {1'b0, FAULT == 3'h2, 1'b0};
	assign PHASE_DEV_A_PCT = {4'h0, jit};
	assign PHASE_DEV_B_PCT = {4'h0, ~jit};
	assign PHASE_DEV_C_PCT = FAULT == 3'h3 ? 8'h15 : 8'h00;
	assign FREQ_DHZ = FAULT == 3'h4 ? 10'h077 : 10'h258;
	assign IB_DPU = FAULT == 3'h5 ? 8'h1F : 8'h0A;
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench of eps_top with a refusal model of the settings.
 * Assumes eps_partner and eps_asserts are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "eps_defs.svh"

module tb;
	import eps_pkg::*;
	localparam int TC = 4;
	int	errors = 0, num_checks = 0, seed = 45731, k, cur_sl = 10;
	int	s, f, o, e, l, u, d, t;
	int	exp_q[$];
	logic	clk = 1'b0, rst = 1'b1, ld = 1'b0, ret = 1'b0, sec = 1'b0;
	logic	tie_c = 1'b1, gen_c = 1'b1, s3 = 1'b1, xfer = 1'b1;
	logic	tkov = 1'b0, keep = 1'b0, fov_rl = 1'b1;
	logic [2:0]	flt = 3'h0, nv = 3'h0, last_al, pl;
	logic [7:0]	fv = 8'h00, fi = 8'h00, lv = 8'h00, gv, da, db, dc, ib;
	logic [7:0]	c_fov = 8'hFA, c_oel = 8'h96, c_el = 8'h96, c_usp = 8'h64;
	logic [4:0]	c_sl = 5'h0A;
	logic [3:0]	c_ld = 4'hA, c_ud = 4'hA;
	logic [12:0]	c_ss = 13'h000A;
	logic [9:0]	fq;
	logic	rej, relay, i_sl, i_fov, i_oel, i_uel, dis, fcm, tk, ss, hold;
	logic	uf = 1'b0, fov_sd = 1'b0, lim_sd = 1'b0, uel_sd = 1'b0, ufp;
	logic [12:0]	sse;

	always #50 clk = ~clk;

	eps_partner u_eps_partner (.CORE_CLK(clk), .FAULT(flt), .GEN_V_PCT(gv),
		.PHASE_LOST(pl), .PHASE_DEV_A_PCT(da), .PHASE_DEV_B_PCT(db),
		.PHASE_DEV_C_PCT(dc), .FREQ_DHZ(fq), .IB_DPU(ib));
	eps_top #(.TICK_CYCLES(TC)) u_eps_top (.CORE_CLK(clk), .RST(rst),
		.GEN_V_PCT(gv), .PHASE_LOST(pl), .PHASE_DEV_A_PCT(da),
		.PHASE_DEV_B_PCT(db), .PHASE_DEV_C_PCT(dc), .FREQ_DHZ(fq),
		.IB_DPU(ib), .FIELD_V(fv), .FIELD_I_DA(fi), .LEAD_VAR_PCT(lv),
		.TIE_BRK_CLOSED(tie_c), .GEN_BRK_CLOSED(gen_c), .UF_ACTIVE(uf),
		.VM_MATCHED(1'b1), .NV_LAST_ALARM(nv), .SENSE_3PH(s3),
		.SL_ACTION_XFER(xfer), .FOV_ACT_RELAY(fov_rl),
		.FOV_ACT_SHUTDOWN(fov_sd), .LIM_TAKEOVER(tkov),
		.LIM_HW_SHUTDOWN(lim_sd), .SECOND_LIM_EN(sec),
		.UEL_HW_SHUTDOWN(uel_sd), .VM_MAINTAIN(keep), .RETURN_AUTO(ret),
		.CFG_LOAD(ld), .CFG_SL_DELAY(c_sl), .CFG_FOV_SP(c_fov),
		.CFG_OEL_SP(c_oel), .CFG_EL_SP(c_el), .CFG_LIM_DELAY(c_ld),
		.CFG_UEL_SP(c_usp), .CFG_UEL_DELAY(c_ud), .CFG_SS_TIME(c_ss),
		.CFG_REJECT(rej), .ALARM_RELAY_CLOSED(relay),
		.IND_SENSE_LOSS(i_sl), .IND_FOV_SHUTDOWN(i_fov),
		.IND_OEL_LIMITING(i_oel), .IND_UEL_LIMITING(i_uel), .DISABLE(dis),
		.FIELD_CURRENT_MODE(fcm), .TAKEOVER_FORCE(tk),
		.SOFT_START_ACTIVE(ss), .SS_ELAPSED(sse), .UF_PRIORITY(ufp),
		.VM_HOLD_BUS(hold), .LAST_ALARM(last_al));

	function automatic logic refuse(int s, f, o, e, l, u, d, t);
		return s > `EPS_SL_DLY_MAX || f > `EPS_FOV_SP_MAX ||
			o > `EPS_LIM_SP_MAX || e > o || l > `EPS_LIM_DLY_MAX ||
			u > `EPS_UEL_SP_MAX || d > `EPS_LIM_DLY_MAX ||
			t < `EPS_SS_MIN || t > `EPS_SS_MAX;
	endfunction

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task chk(input string n, input logic x, input logic g);
		num_checks++;
		if (g !== x) begin
			errors++;
			$display("ERROR %s expected %b seen %b", n, x, g);
		end
	endtask

	task chk_alarm(input logic [2:0] x);
		num_checks++;
		if (last_al !== x) begin
			errors++;
			$display("ERROR last_alarm expected %0h seen %0h", x, last_al);
		end
	endtask

	// Power cycle with the given cause standing in the store
	task reboot(input logic [2:0] code);
		nv <= code;
		rst <= 1'b1;
		cyc(8);
		rst <= 1'b0;
		cyc(4);
	endtask

	// Whole set is taken or refused together; model keeps accepted delay
	task load();
		c_sl <= 5'(s);
		c_fov <= 8'(f);
		c_oel <= 8'(o);
		c_el <= 8'(e);
		c_ld <= 4'(l);
		c_usp <= 8'(u);
		c_ud <= 4'(d);
		c_ss <= 13'(t);
		ld <= 1'b1;
		exp_q.push_back(int'(refuse(s, f, o, e, l, u, d, t)));
		cyc(1);
		ld <= 1'b0;
		cyc(1);
		if (exp_q[0] == 0)
			cur_sl = s;
		chk("cfg_reject", exp_q.pop_front() != 0, rej);
	endtask

	task print_verdict();
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		cyc(8);
		rst <= 1'b0;
		cyc(2);
		for (k = 0; k < 10; k++) begin
			s = {$random(seed)} % 26;
			f = {$random(seed)} % 251;
			o = {$random(seed)} % 151;
			e = {$random(seed)} % (o + 1);
			l = {$random(seed)} % 11;
			u = {$random(seed)} % 101;
			d = {$random(seed)} % 11;
			t = 1 + {$random(seed)} % 7200;
			sec <= 1'($random(seed));
			case (k)
			1: f = 251;
			2: e = o + 1;
			3: s = 26;
			4: t = 0;
			5: t = 7201;
			6: u = 101;
			7: l = 11;
			8: d = 11;
			9: o = 151;
			default: ;
			endcase
			load();
		end
		s = 2; f = 200; o = 100; e = 60; l = 1; u = 50; d = 1; t = 1;
		load();
		sec <= 1'b0;
		cyc(2);
		chk("soft_start", 1'b0, ss);
		for (k = 4; k < 6; k++) begin
			flt <= 3'(k);
			cyc(12);
			chk("inhibit_ind", 1'b0, i_sl);
			chk("inhibit_mode", 1'b0, fcm);
		end
		s3 <= 1'b0;
		flt <= 3'h2;
		cyc(12);
		chk("one_phase", 1'b0, i_sl);
		s3 <= 1'b1;
		cyc(3);
		chk("xfer_relay", 1'b0, relay);
		chk("xfer_ind", 1'b1, i_sl);
		chk("xfer_early", 1'b0, fcm);
		cyc(TC * cur_sl + 3);
		chk("xfer_mode", 1'b1, fcm);
		flt <= 3'h0;
		cyc(3);
		chk("xfer_clear", 1'b0, i_sl);
		chk("xfer_hold", 1'b1, fcm);
		ret <= 1'b1;
		cyc(1);
		ret <= 1'b0;
		cyc(2);
		chk("return_auto", 1'b0, fcm);
		flt <= 3'h3;
		cyc(3);
		chk("deviation", 1'b1, i_sl);
		flt <= 3'h0;
		lv <= 8'h5A;
		cyc(12);
		chk("uel_closed", 1'b0, i_uel);
		chk("paralleled_hold", 1'b1, hold);
		tie_c <= 1'b0;
		cyc(3);
		chk("uel_ind", 1'b1, i_uel);
		chk("revert", 1'b0, hold);
		keep <= 1'b1;
		cyc(TC + 3);
		chk("uel_relay", 1'b0, relay);
		chk("maintain", 1'b1, hold);
		keep <= 1'b0;
		lv <= 8'h00;
		tie_c <= 1'b1;
		cyc(3);
		fi <= 8'h65;
		cyc(2);
		chk("oel_ind", 1'b1, i_oel);
		chk("oel_early", 1'b1, relay);
		cyc(TC + 2);
		chk("oel_relay", 1'b0, relay);
		tkov <= 1'b1;
		cyc(3);
		chk("takeover", 1'b1, tk);
		fi <= 8'h00;
		tkov <= 1'b0;
		fv <= 8'hC9;
		cyc(3);
		chk("fov_early", 1'b0, i_fov);
		cyc(TC * 10 + 2);
		chk("fov_ind", 1'b1, i_fov);
		chk("fov_relay", 1'b0, relay);
		fv <= 8'h00;
		xfer <= 1'b0;
		flt <= 3'h1;
		cyc(3);
		chk("sd_ind", 1'b1, i_sl);
		chk("sd_early", 1'b0, dis);
		cyc(TC * cur_sl + 3);
		chk("sd_disable", 1'b1, dis);
		chk_alarm(EPS_ALM_SENSE);
		flt <= 3'h0;
		uf <= 1'b1;
		reboot(EPS_ALM_SENSE);
		chk("boot_ind", 1'b1, i_sl);
		chk("boot_soft", 1'b1, ss);
		chk("boot_uf", 1'b1, ufp);
		chk("boot_dis", 1'b0, dis);
		cyc(TC * 5 + 2);
		chk("boot_end", 1'b0, i_sl);
		// Loss appearing during soft start waits it out, then its own delay
		flt <= 3'h1;
		cyc(TC * `EPS_SS_RST);
		chk("persist_early", 1'b0, dis);
		chk("persist_ind", 1'b1, i_sl);
		chk("uf_after", 1'b0, ufp);
		num_checks++;
		if (sse !== `EPS_SS_RST) begin
			errors++;
			$display("ERROR ss_elapsed expected %0d seen %0d", `EPS_SS_RST, sse);
		end
		cyc(TC * `EPS_SL_DLY_RST + 8);
		chk("persist_sd", 1'b1, dis);
		flt <= 3'h0;
		fov_sd <= 1'b1;
		fov_rl <= 1'b0;
		reboot(EPS_ALM_NONE);
		fv <= 8'hFB;
		cyc(TC * `EPS_FOV_DELAY_S + 8);
		chk("fov_sd", 1'b1, dis);
		chk("fov_sd_ind", 1'b0, i_fov);
		chk_alarm(EPS_ALM_FOV);
		fv <= 8'h00;
		fov_sd <= 1'b0;
		reboot(EPS_ALM_FOV);
		chk("fov_boot", 1'b1, i_fov);
		fi <= 8'h97;
		lim_sd <= 1'b1;
		cyc(TC * `EPS_LIM_DLY_RST + 8);
		chk("oel_sd", 1'b1, dis);
		chk_alarm(EPS_ALM_OEL);
		fi <= 8'h00;
		lim_sd <= 1'b0;
		reboot(EPS_ALM_OEL);
		chk("oel_boot", 1'b1, i_oel);
		tie_c <= 1'b0;
		lv <= 8'h65;
		uel_sd <= 1'b1;
		cyc(TC * `EPS_UEL_DLY_RST + 8);
		chk("uel_sd", 1'b1, dis);
		chk_alarm(EPS_ALM_UEL);
		tie_c <= 1'b1;
		lv <= 8'h00;
		uel_sd <= 1'b0;
		reboot(EPS_ALM_UEL);
		chk("uel_boot", 1'b1, i_uel);
		cyc(TC * `EPS_BOOT_SHOW_S + 2);
		chk("uel_boot_end", 1'b0, i_uel);
		print_verdict();
	end
endmodule
`default_nettype wire
